// ### src/acs_pkg.sv
// Constants, register map and carrier types for the conversion sequencer
package acs_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_MODE    = 8'h00;
  localparam logic [7:0] ADDR_CMD     = 8'h04;
  localparam logic [7:0] ADDR_RESULT  = 8'h08;
  localparam logic [7:0] ADDR_FLAG    = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h10;
  localparam logic [7:0] ADDR_TRIG    = 8'h14;

  // Mode, result and trigger register fields
  localparam int MODE_DIS_BIT   = 0;
  localparam int MODE_DBG_LSB   = 1;
  localparam int RESULT_CMD_LSB = 16;
  localparam int TRIG_EDGE_BIT  = 0;
  localparam int TRIG_POL_BIT   = 1;

  // Conversion method encodings
  localparam logic [1:0] CM_RESET    = 2'h0;
  localparam logic [1:0] CM_PAUSE    = 2'h1;
  localparam logic [1:0] CM_TRIGGER  = 2'h2;
  localparam logic [1:0] CM_CONTINUE = 2'h3;

  // Reset values
  localparam logic       MODE_DIS_RST = 1'b1;
  localparam logic [1:0] DEBUG_RST    = 2'h0;

  // Successive approximation timing
  localparam int SAR_BITS    = 10;
  localparam int CLK_MHZ     = 40;
  localparam int STEP_NS     = 500;
  localparam int STEP_CYCLES = (STEP_NS * CLK_MHZ) / 1000;

  typedef struct packed {
    logic [3:0] channel;
    logic       per_command_irq;
    logic [1:0] conversion_method;
  } acs_cmd_t;

  typedef struct packed {
    logic queue_full_flag;
    logic queue_empty_flag;
    logic result_lost_flag;
    logic trigger_overrun_flag;
    logic paused_flag;
    logic complete_flag;
  } acs_flags_t;

  localparam int CMD_W  = $bits(acs_cmd_t);
  localparam int FLAG_W = $bits(acs_flags_t);

endpackage

// ### src/acs_sar.sv
// Successive approximation stepper driving the DAC code
`timescale 1ns/10ps
module acs_sar
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // Control
  input  wire logic                start,
  input  wire logic                abort,
  input  wire logic                cmp_above,
  // Status
  output logic                     done,
  output logic [SAR_BITS-1:0]      dac_code
);

  localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES - 1);

  logic                busy_q;
  logic [7:0]          cnt_q;
  logic [SAR_BITS-1:0] bit_q;

  always_ff @(posedge mclk) begin
    if (rst || abort) begin
      busy_q   <= 1'b0;
      cnt_q    <= 8'h00;
      bit_q    <= '0;
      dac_code <= '0;
      done     <= 1'b0;
    end else if (start) begin
      busy_q   <= 1'b1;
      cnt_q    <= 8'h00;
      bit_q    <= {1'b1, {(SAR_BITS-1){1'b0}}};
      dac_code <= {1'b1, {(SAR_BITS-1){1'b0}}};
      done     <= 1'b0;
    end else if (busy_q && cnt_q == STEP_LAST) begin
      // Keep trial bit if input above DAC, then try next bit
      cnt_q    <= 8'h00;
      bit_q    <= bit_q >> 1;
      dac_code <= (cmp_above ? dac_code : (dac_code & ~bit_q)) | (bit_q >> 1);
      busy_q   <= ~bit_q[0];
      done     <= bit_q[0];
    end else begin
      cnt_q    <= busy_q ? cnt_q + 8'h01 : 8'h00;
      done     <= 1'b0;
    end
  end

endmodule

// ### src/acs_sequencer.sv
// Conversion sequencer top: APB registers, command queue, control and flags
`timescale 1ns/10ps
module acs_sequencer
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Analog side
  input  wire logic                cmp_in,
  input  wire logic                ext_trigger,
  output logic [SAR_BITS-1:0]      dac_code,
  output logic [3:0]               channel_sel,
  output logic                     analog_enable,
  // DMA and interrupt
  output logic                     dma_cmd_req,
  output logic                     dma_result_req,
  output logic                     irq
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_TRIG,
    ST_CONVERT,
    ST_WAIT_CMD
  } acs_state_t;

  acs_state_t         state_q;
  acs_state_t         state_d;
  logic               mod_dis_q;
  logic [1:0]         debug_q;
  logic               trig_edge_q;
  logic               trig_pol_q;
  acs_cmd_t           queued_q;
  logic               queued_valid_q;
  acs_cmd_t           current_q;
  logic [31:0]        result_q;
  logic               result_unread_q;
  acs_flags_t         flags_q;
  logic [FLAG_W-1:0]  irq_en_q;
  logic               last_gi_q;
  logic               cmp_s1_q;
  logic               cmp_s2_q;
  logic               trg_s1_q;
  logic               trg_s2_q;
  logic               trg_hist_q;

  // Bus decode
  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic        setup;
  logic        mapped;
  acs_cmd_t    wr_cmd;
  logic        cmd_wr;
  logic        abort_wr;
  logic        start_wr;
  logic        result_rd;
  logic        flag_rd;
  logic        trig_lvl;
  logic        trig_edge;
  logic        trig_hit;
  logic        conv_done;
  logic        conv_start;
  logic        take_queue;
  logic        abort_all;
  logic        dis_wr;
  logic        queue_wr;
  logic [31:0] rd_mux;

  assign setup     = psel && !penable;
  assign acc       = psel && penable && pready;
  assign wr_acc    = acc && pwrite && !pslverr;
  assign rd_acc    = acc && !pwrite && !pslverr;
  assign wr_cmd    = acs_cmd_t'(pwdata[CMD_W-1:0]);
  assign cmd_wr    = wr_acc && paddr == ADDR_CMD;
  assign abort_wr  = cmd_wr && wr_cmd.conversion_method == CM_RESET;
  assign start_wr  = cmd_wr && !abort_wr && !mod_dis_q;
  assign result_rd = rd_acc && paddr == ADDR_RESULT;
  assign flag_rd   = rd_acc && paddr == ADDR_FLAG;
  assign mapped    = paddr == ADDR_MODE || paddr == ADDR_CMD || paddr == ADDR_RESULT ||
                     paddr == ADDR_FLAG || paddr == ADDR_IRQ_EN || paddr == ADDR_TRIG;
  // Disabling also drops everything in flight, from the write itself on
  assign dis_wr    = wr_acc && paddr == ADDR_MODE && pwdata[MODE_DIS_BIT];
  assign abort_all = abort_wr || dis_wr || mod_dis_q;
  // Command writes that fill the visible register rather than start at once
  assign queue_wr  = cmd_wr && !(state_q == ST_IDLE && start_wr);

  // Pin synchronisers
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmp_s1_q   <= 1'b0;
      cmp_s2_q   <= 1'b0;
      trg_s1_q   <= 1'b0;
      trg_s2_q   <= 1'b0;
      trg_hist_q <= 1'b0;
    end else begin
      cmp_s1_q   <= cmp_in;
      cmp_s2_q   <= cmp_s1_q;
      trg_s1_q   <= ext_trigger;
      trg_s2_q   <= trg_s1_q;
      trg_hist_q <= trg_s2_q;
    end
  end

  // Trigger: polarity select, then edge or level
  assign trig_lvl  = trg_s2_q ^ ~trig_pol_q;
  assign trig_edge = trig_lvl && !(trg_hist_q ^ ~trig_pol_q);
  assign trig_hit  = trig_edge_q ? trig_edge : trig_lvl;

  // APB handshake: data registered in setup, ready in first access cycle
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      ADDR_MODE:   rd_mux = {29'h0000_0000, debug_q, mod_dis_q};
      ADDR_CMD:    rd_mux = {{(32-CMD_W){1'b0}}, queued_q};
      ADDR_RESULT: rd_mux = result_q;
      ADDR_FLAG:   rd_mux = {{(32-FLAG_W){1'b0}}, flags_q};
      ADDR_IRQ_EN: rd_mux = {{(32-FLAG_W){1'b0}}, irq_en_q};
      ADDR_TRIG:   rd_mux = {30'h0000_0000, trig_pol_q, trig_edge_q};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pready  <= 1'b1;
      pslverr <= !mapped;
    end else begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Software configuration registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      mod_dis_q   <= MODE_DIS_RST;
      debug_q     <= DEBUG_RST;
      irq_en_q    <= '0;
      trig_edge_q <= 1'b1;
      trig_pol_q  <= 1'b1;
    end else if (wr_acc) begin
      if (paddr == ADDR_MODE) begin
        mod_dis_q <= pwdata[MODE_DIS_BIT];
        debug_q   <= pwdata[MODE_DBG_LSB +: 2];
      end
      if (paddr == ADDR_IRQ_EN) begin
        irq_en_q <= pwdata[FLAG_W-1:0];
      end
      if (paddr == ADDR_TRIG) begin
        trig_edge_q <= pwdata[TRIG_EDGE_BIT];
        trig_pol_q  <= pwdata[TRIG_POL_BIT];
      end
    end
  end

  // Converter block
  acs_sar u_sar (
    .mclk      (mclk),
    .rst       (rst),
    .start     (conv_start),
    .abort     (abort_all),
    .cmp_above (cmp_s2_q),
    .done      (conv_done),
    .dac_code  (dac_code)
  );

  // Conversion control, driven by the written, queued and current commands
  assign take_queue = state_q == ST_WAIT_CMD && queued_valid_q;
  always_comb begin
    state_d    = state_q;
    conv_start = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (start_wr) begin
          // Write is the trigger for methods 01 and 11
          state_d    = wr_cmd.conversion_method == CM_TRIGGER ? ST_WAIT_TRIG : ST_CONVERT;
          conv_start = wr_cmd.conversion_method != CM_TRIGGER;
        end
      end
      ST_WAIT_TRIG: begin
        if (trig_hit) begin
          state_d    = ST_CONVERT;
          conv_start = 1'b1;
        end
      end
      ST_CONVERT: begin
        if (conv_done) begin
          state_d = current_q.conversion_method == CM_PAUSE ? ST_IDLE : ST_WAIT_CMD;
        end
      end
      ST_WAIT_CMD: begin
        if (take_queue) begin
          state_d    = queued_q.conversion_method == CM_TRIGGER ? ST_WAIT_TRIG : ST_CONVERT;
          conv_start = queued_q.conversion_method != CM_TRIGGER;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (abort_all) begin
      state_d    = ST_IDLE;
      conv_start = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Current command and queue
  always_ff @(posedge mclk) begin
    if (rst || abort_all) begin
      current_q      <= '0;
      queued_q       <= '0;
      queued_valid_q <= 1'b0;
    end else begin
      if (state_q == ST_IDLE && start_wr) begin
        current_q <= wr_cmd;
      end else if (take_queue) begin
        current_q <= queued_q;
      end
      // Visible register accepts the next command in any state but idle
      if (queue_wr) begin
        queued_q       <= wr_cmd;
        queued_valid_q <= 1'b1;
      end else if (take_queue) begin
        queued_valid_q <= 1'b0;
      end
    end
  end

  // Result register with command copy
  always_ff @(posedge mclk) begin
    if (rst) begin
      result_q        <= 32'h0000_0000;
      result_unread_q <= 1'b0;
      last_gi_q       <= 1'b0;
    end else if (conv_done && !abort_all) begin
      result_q <= {{(16-CMD_W){1'b0}}, current_q, {(16-SAR_BITS){1'b0}}, dac_code};
      result_unread_q <= 1'b1;
      last_gi_q       <= current_q.per_command_irq;
    end else if (result_rd) begin
      result_unread_q <= 1'b0;
    end
  end

  // DMA requests
  always_ff @(posedge mclk) begin
    if (rst || abort_all) begin
      dma_cmd_req    <= 1'b0;
      dma_result_req <= 1'b0;
    end else begin
      // A starting write is not a fetched command: it asks for the next one
      if (queue_wr) begin
        dma_cmd_req <= 1'b0;
      end else if (conv_start) begin
        dma_cmd_req <= 1'b1;
      end else if (conv_done && current_q.conversion_method == CM_PAUSE) begin
        dma_cmd_req <= 1'b0;
      end
      if (conv_done) begin
        dma_result_req <= 1'b1;
      end else if (result_rd) begin
        dma_result_req <= 1'b0;
      end
    end
  end

  // Sticky flags: set wins over read clear
  logic rd_clr;
  assign rd_clr = flag_rd && debug_q == 2'h0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      if (conv_done && current_q.per_command_irq) begin
        flags_q.complete_flag <= 1'b1;
      end else if (rd_clr) begin
        flags_q.complete_flag <= 1'b0;
      end
      if (conv_done && current_q.conversion_method == CM_PAUSE) begin
        flags_q.paused_flag <= 1'b1;
      end else if (rd_clr) begin
        flags_q.paused_flag <= 1'b0;
      end
      if (state_q == ST_CONVERT && current_q.conversion_method == CM_TRIGGER &&
          trig_edge_q && trig_edge) begin
        flags_q.trigger_overrun_flag <= 1'b1;
      end else if (rd_clr) begin
        flags_q.trigger_overrun_flag <= 1'b0;
      end
      if (conv_done && result_unread_q && !result_rd) begin
        flags_q.result_lost_flag <= 1'b1;
      end else if (rd_clr) begin
        flags_q.result_lost_flag <= 1'b0;
      end
      // Queue flags track the queue, not cleared by read
      if (conv_done && !queued_valid_q) begin
        flags_q.queue_empty_flag <= 1'b1;
      end else if (cmd_wr || abort_all) begin
        flags_q.queue_empty_flag <= 1'b0;
      end
      flags_q.queue_full_flag <= state_d == ST_CONVERT &&
                                 (queued_valid_q || (cmd_wr && state_q == ST_CONVERT)) &&
                                 !take_queue && !abort_all;
    end
  end

  // Shared interrupt line
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |({flags_q[FLAG_W-1:1], flags_q.complete_flag & last_gi_q} & irq_en_q);
    end
  end

  // Analog side outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      channel_sel   <= 4'h0;
      analog_enable <= 1'b0;
    end else begin
      channel_sel   <= current_q.channel;
      analog_enable <= !mod_dis_q;
    end
  end

endmodule

// ### testbench/acs_cmp_model.sv
// Comparator model of the analog front end
`timescale 1ns/10ps
module acs_cmp_model
  import acs_pkg::*;
(
  // Trial code and analog level
  input  wire logic [SAR_BITS-1:0] dac_code,
  input  wire logic [SAR_BITS-1:0] level,
  // Comparator output
  output logic                     cmp_in
);
  // Input sits half a step above level, so the search ends on level
  assign cmp_in = (dac_code <= level);
endmodule

// ### testbench/acs_seq_checker.sv
// Port-level assertions for the conversion sequencer
`timescale 1ns/10ps
module acs_seq_checker
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        pready,
  // Status
  input  wire logic        analog_enable,
  input  wire logic        dma_cmd_req,
  input  wire logic        dma_result_req,
  input  wire logic        irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic acc;
  logic cmd_wr;
  logic res_rd;
  logic stop_wr;
  assign acc     = psel && penable && pready;
  assign cmd_wr  = acc && pwrite && (paddr == ADDR_CMD);
  assign res_rd  = acc && !pwrite && (paddr == ADDR_RESULT);
  assign stop_wr = (cmd_wr && (pwdata[1:0] == CM_RESET))
                || (acc && pwrite && (paddr == ADDR_MODE) && pwdata[MODE_DIS_BIT]);
  property p_reset_quiet;
    $fell(rst) |-> !(dma_cmd_req || dma_result_req || irq || analog_enable);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  property p_fetch_enabled;
    dma_cmd_req |-> analog_enable;
  endproperty
  a_fetch_enabled: assert property (p_fetch_enabled) else $error("converting while off");
  property p_abort;
    stop_wr |=> !dma_cmd_req && !dma_result_req;
  endproperty
  a_abort: assert property (p_abort) else $error("abort left requests");
  property p_cmd_drop;
    cmd_wr && dma_cmd_req |=> !dma_cmd_req;
  endproperty
  a_cmd_drop: assert property (p_cmd_drop) else $error("fetch request kept");
  property p_res_drop;
    res_rd |=> !dma_result_req;
  endproperty
  a_res_drop: assert property (p_res_drop) else $error("store request kept");
  property p_res_stays;
    dma_result_req && !res_rd && !stop_wr |=> dma_result_req;
  endproperty
  a_res_stays: assert property (p_res_stays) else $error("store request lost");
  property p_write_start;
    cmd_wr && pwdata[0] && analog_enable && !dma_cmd_req |-> ##[2:3] dma_cmd_req;
  endproperty
  a_write_start: assert property (p_write_start) else $error("write did not start");
  property p_no_early;
    $rose(dma_cmd_req) |=> (!$rose(dma_result_req)) [*8];
  endproperty
  a_no_early: assert property (p_no_early) else $error("result too early");
  c_start: cover property (cmd_wr ##3 dma_cmd_req);
  c_done: cover property ($rose(dma_result_req));
  c_abort: cover property (stop_wr);
endmodule

// ### testbench/test_adc_conversion_sequencer.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module test_adc_conversion_sequencer;
  import acs_pkg::*;
  localparam logic [SAR_BITS-1:0] LEVEL = 10'h2A5;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, err_q;
  logic cmp_in, ext_trigger, analog_enable, dma_cmd_req, dma_result_req, irq;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, rd_q;
  logic [SAR_BITS-1:0] dac_code;
  logic [3:0]          channel_sel;
  int                  n_fail, samples_checked;

  acs_sequencer dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_in(cmp_in), .ext_trigger(ext_trigger), .dac_code(dac_code),
    .channel_sel(channel_sel), .analog_enable(analog_enable), .dma_cmd_req(dma_cmd_req),
    .dma_result_req(dma_result_req), .irq(irq));
  acs_cmp_model u_cmp (.dac_code(dac_code), .level(LEVEL), .cmp_in(cmp_in));

  always #12.5 mclk = ~mclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Result request when res is set, otherwise end of the fetch request
  task automatic wait_for(input bit res);
    int i;
    i = 0;
    while (i < 400 && (res ? dma_result_req : !dma_cmd_req) !== 1'b1) begin
      i++;
      @(posedge mclk);
    end
    // Running out of the limit counts as a mismatch
    chk(res ? dma_result_req : !dma_cmd_req, 32'h1);
    cyc(3);
  endtask

  function automatic logic [31:0] res_exp(input logic [6:0] c);
    return {9'h000, c, 6'h00, LEVEL};
  endfunction

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    summarize();
  end

  initial begin
    {mclk, psel, penable, pwrite, ext_trigger, paddr, pwdata} = '0;
    rst = 1'b1;
    n_fail = 0;
    samples_checked = 0;
    cyc(3);
    rst <= 1'b0;
    cyc(1);
    chk(analog_enable, 32'h0);
    rd(ADDR_MODE, 32'h1);
    rd(ADDR_IRQ_EN, 32'h0);
    rd(ADDR_TRIG, 32'h3);
    rd(8'h18, 32'h0);
    chk(err_q, 32'h1);
    apb(1'b1, ADDR_CMD, 32'h2D);
    cyc(3);
    chk(dma_cmd_req, 32'h0);
    apb(1'b1, ADDR_MODE, 32'h0);
    apb(1'b1, ADDR_IRQ_EN, 32'h1);
    $display("test reset done");
    // Pause method, channel 5, completion interrupt requested
    apb(1'b1, ADDR_CMD, 32'h2D);
    cyc(3);
    chk(dma_cmd_req, 32'h1);
    chk(channel_sel, 32'h5);
    wait_for(1'b1);
    chk(dma_cmd_req, 32'h0);
    chk(irq, 32'h1);
    cyc(10);
    chk(dma_cmd_req, 32'h0);
    rd(ADDR_RESULT, res_exp(7'h2D));
    cyc(1);
    chk(dma_result_req, 32'h0);
    rd(ADDR_FLAG, 32'h13);
    rd(ADDR_FLAG, 32'h10);
    cyc(2);
    chk(irq, 32'h0);
    $display("test pause done");
    // Continuous pair, second queued, first result left unread
    apb(1'b1, ADDR_CMD, 32'h1B);
    cyc(3);
    chk(dma_cmd_req, 32'h1);
    apb(1'b1, ADDR_CMD, 32'h23);
    cyc(1);
    chk(dma_cmd_req, 32'h0);
    rd(ADDR_FLAG, 32'h20);
    wait_for(1'b1);
    chk(dma_cmd_req, 32'h1);
    chk(channel_sel, 32'h4);
    // Second conversion ends while the first result is still unread
    cyc(220);
    rd(ADDR_FLAG, 32'h18);
    rd(ADDR_RESULT, res_exp(7'h23));
    apb(1'b1, ADDR_CMD, 32'h1B);
    cyc(3);
    apb(1'b1, ADDR_CMD, 32'h0);
    cyc(2);
    chk(dma_cmd_req, 32'h0);
    cyc(250);
    chk(dma_result_req, 32'h0);
    rd(ADDR_FLAG, 32'h0);
    $display("test continuous done");
    // Triggered method with a second edge in flight
    apb(1'b1, ADDR_IRQ_EN, 32'h4);
    apb(1'b1, ADDR_CMD, 32'h02);
    cyc(10);
    chk(dma_cmd_req, 32'h0);
    ext_trigger <= 1'b1;
    cyc(6);
    chk(dma_cmd_req, 32'h1);
    ext_trigger <= 1'b0;
    cyc(6);
    ext_trigger <= 1'b1;
    cyc(6);
    ext_trigger <= 1'b0;
    wait_for(1'b1);
    chk(irq, 32'h1);
    rd(ADDR_FLAG, 32'h14);
    rd(ADDR_RESULT, res_exp(7'h02));
    $display("test trigger done");
    // Debug setting keeps flags on read
    apb(1'b1, ADDR_MODE, 32'h2);
    apb(1'b1, ADDR_CMD, 32'h01);
    wait_for(1'b1);
    rd(ADDR_FLAG, 32'h12);
    rd(ADDR_FLAG, 32'h12);
    $display("test debug done");
    summarize();
  end
endmodule

bind acs_sequencer acs_seq_checker u_chk (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .analog_enable(analog_enable), .dma_cmd_req(dma_cmd_req),
  .dma_result_req(dma_result_req), .irq(irq));
